// ==== test_watchdog_interrupt_flag_logic.sv ====
module test_watchdog_interrupt_flag_logic;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, te = 1'b0, dt = 1'b0, ce = 1'b1, rs, ck, sr, irq;
    logic [1:0] ps;
    logic [7:0] rdd;
    watchdog_interrupt_flag_pkg::watchdog_interrupt_flag_bus_s bus = '0;
    int n_errors = 0, compares = 0;
    initial forever #2 clk = ~clk;
    watchdog_interrupt_flag_top u_dut (.CORE_CLK(clk), .RST(rst), .CE(ce), .BUS(bus), .RD_DATA(rdd), .TIMEOUT_EVT(te),
        .DIV_TICK(dt), .WDT_RESTART(rs), .PERIOD_SEL(ps), .WDT_CLK_EN(ck), .SYS_RST_REQ(sr), .IRQ(irq));
    task chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // One bus cycle: w=1 writes, w=0 reads; read data checked right after return
    task acc(input logic [1:0] a, input logic [7:0] d, input logic w);
        @(posedge clk) bus <= '{a, d, w, !w};
        @(posedge clk) bus <= '0;
        #1;
    endtask
    task tick(input int n);
        @(posedge clk) dt <= 1'b1;
        repeat (n) @(posedge clk);
        dt <= 1'b0;
        #1;
    endtask
    task tmo;
        @(posedge clk) te <= 1'b1;
        @(posedge clk) te <= 1'b0;
    endtask
    task rst3;
        @(posedge clk) rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
    endtask
    task conclude;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        rst3;
        acc(2'h0, 8'h00, 1'b0); chk(rdd, 8'h00);
        acc(2'h0, 8'h30, 1'b1); chk(8'(ps), 8'h00);
        acc(2'h0, 8'h21, 1'b1); chk(8'(ps), 8'h02);
        chk(8'(rs), 8'h01);
        $display("test 1 done");
        tmo; acc(2'h0, 8'h00, 1'b0); chk(rdd, 8'h20);
        chk(8'(ck), 8'h00);
        acc(2'h0, 8'h04, 1'b1); chk(8'(ck), 8'h01);
        tmo; acc(2'h0, 8'h00, 1'b0); chk(rdd, 8'h2c);
        chk(8'(irq), 8'h01);
        acc(2'h1, 8'h00, 1'b0); chk(rdd, 8'h01);
        acc(2'h0, 8'h06, 1'b1); acc(2'h0, 8'h00, 1'b0); chk(rdd, 8'h26);
        chk(8'(irq), 8'h00);
        tick(511); acc(2'h1, 8'h00, 1'b0); chk(rdd, 8'h01);
        chk(8'(sr), 8'h00);
        tick(1); acc(2'h1, 8'h00, 1'b0); chk(rdd, 8'h03);
        chk(8'(sr), 8'h01);
        $display("test 2 done");
        rst3;
        chk(8'(sr), 8'h00);
        // Reset enable alone: the flag is set but no interrupt follows
        acc(2'h0, 8'h02, 1'b1); tmo; acc(2'h0, 8'h00, 1'b0); chk(rdd, 8'h0a);
        chk(8'(irq), 8'h00);
        acc(2'h0, 8'h0e, 1'b1); acc(2'h1, 8'h00, 1'b0); chk(rdd, 8'h01);
        chk(8'(irq), 8'h01);
        tick(300); acc(2'h0, 8'h07, 1'b1); tick(600); acc(2'h1, 8'h00, 1'b0); chk(rdd, 8'h01);
        chk(8'(sr | irq), 8'h00);
        acc(2'h2, 8'h01, 1'b1); acc(2'h3, 8'h00, 1'b0); chk(rdd, 8'h00);
        chk(8'(irq), 8'h01);
        acc(2'h1, 8'h01, 1'b1); acc(2'h3, 8'h00, 1'b0); chk(8'(irq), 8'h00);
        $display("test 3 done");
        // A flag-setting write while the clock enable is low must be lost
        @(posedge clk) ce <= 1'b0;
        acc(2'h0, 8'h08, 1'b1);
        @(posedge clk) ce <= 1'b1;
        acc(2'h0, 8'h00, 1'b0); chk(rdd, 8'h06);
        chk(8'(irq), 8'h00);
        $display("test 4 done");
        conclude;
    end
endmodule

// ==== watchdog_interrupt_flag_chk_asserts.sv ====
module watchdog_interrupt_flag_chk (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire watchdog_interrupt_flag_pkg::watchdog_interrupt_flag_bus_s BUS,
    input wire logic [watchdog_interrupt_flag_pkg::DATA_W-1:0] RD_DATA,
    input wire logic TIMEOUT_EVT,
    input wire logic DIV_TICK,
    input wire logic WDT_RESTART,
    input wire logic [1:0] PERIOD_SEL,
    input wire logic WDT_CLK_EN,
    input wire logic SYS_RST_REQ,
    input wire logic IRQ
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    logic cw;
    logic rw;
    assign cw = BUS.wr && CE && BUS.addr == 2'h0;
    // Only a restarting write may touch the period select
    assign rw = cw && BUS.wdata[0];
    a_restart_pulse: assert property (rw |=> WDT_RESTART)
        else $error("restart pulse missing");
    a_psel_take: assert property (rw |=> PERIOD_SEL == $past(BUS.wdata[5:4]))
        else $error("period select not taken");
    a_psel_keep: assert property (!rw |=> $stable(PERIOD_SEL))
        else $error("period select changed");
    a_clk_gate: assert property (cw |=> WDT_CLK_EN == ($past(BUS.wdata[2:1]) != 2'h0))
        else $error("clock enable wrong");
    a_rst_sticky: assert property (SYS_RST_REQ |=> SYS_RST_REQ)
        else $error("reset request dropped");
    a_rst_tick: assert property ($rose(SYS_RST_REQ) |-> $past(DIV_TICK))
        else $error("reset request without tick");
    a_idle_quiet: assert property (TIMEOUT_EVT && CE && !WDT_CLK_EN && !IRQ && !BUS.wr && !$past(BUS.wr)
        && !DIV_TICK |=> !IRQ) else $error("disabled timeout raised irq");
    a_irq_swset: assert property (cw && BUS.wdata[3:2] == 2'h3 |-> ##[1:2] IRQ)
        else $error("software flag gave no irq");
endmodule
bind watchdog_interrupt_flag_top watchdog_interrupt_flag_chk u_chk (.CORE_CLK, .RST, .CE, .BUS, .RD_DATA, .TIMEOUT_EVT, .DIV_TICK,
    .WDT_RESTART, .PERIOD_SEL, .WDT_CLK_EN, .SYS_RST_REQ, .IRQ);

// ==== watchdog_interrupt_flag_pkg.sv ====
package watchdog_interrupt_flag_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [1:0] WATCHDOG_CONTROL_REG_OFS = 2'h0;
    localparam logic [1:0] IRQ_STATUS_OFS = 2'h1;
    localparam logic [1:0] IRQ_MASK_OFS = 2'h2;

    // Control register field positions
    localparam int RESTART_BIT_POS = 0;
    localparam int RESET_EN_POS = 1;
    localparam int INT_EN_POS = 2;
    localparam int FLAG_POS = 3;
    localparam int PSEL_LO_POS = 4;
    localparam int PSEL_HI_POS = 5;

    // Status / mask bit positions
    localparam int EVT_FLAG_POS = 0;
    localparam int EVT_EXPIRE_POS = 1;

    // Reset values
    localparam logic [1:0] PSEL_RST = 2'h0;
    localparam logic RESET_EN_RST = 1'b0;
    localparam logic INT_EN_RST = 1'b0;
    localparam logic [1:0] MASK_RST = 2'h0;

    // Reset counter length in divided clock ticks
    localparam int RST_TICKS = 512;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] RST_TICKS_LAST = CNT_W'(RST_TICKS - 1);

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } watchdog_interrupt_flag_bus_s;

    typedef struct packed {
        logic [1:0] psel;
        logic reset_en;
        logic int_en;
        logic flag;
        logic cnt_run;
        logic [CNT_W-1:0] cnt;
        logic [1:0] status;
        logic [1:0] mask;
        logic [DATA_W-1:0] rdata;
        logic irq;
        logic rst_req;
        logic restart;
        logic clk_en;
    } watchdog_interrupt_flag_state_s;
endpackage

// ==== watchdog_interrupt_flag_top.sv ====
// The implementer's own choices: strobed register access and the register offsets.
module watchdog_interrupt_flag_top (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire watchdog_interrupt_flag_pkg::watchdog_interrupt_flag_bus_s BUS,
    output logic [watchdog_interrupt_flag_pkg::DATA_W-1:0] RD_DATA,
    input wire logic TIMEOUT_EVT,
    input wire logic DIV_TICK,
    output logic WDT_RESTART,
    output logic [1:0] PERIOD_SEL,
    output logic WDT_CLK_EN,
    output logic SYS_RST_REQ,
    output logic IRQ
);
    watchdog_interrupt_flag_pkg::watchdog_interrupt_flag_state_s s_q;
    watchdog_interrupt_flag_pkg::watchdog_interrupt_flag_state_s s_d;

    function automatic logic hit(input logic [watchdog_interrupt_flag_pkg::ADDR_W-1:0] a, input logic [watchdog_interrupt_flag_pkg::ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    logic ctl_wr;
    logic restart_wr;
    logic flag_set;
    logic flag_rise;
    logic expire;
    logic sts_wr;
    logic [1:0] evt_set;
    logic [1:0] status_nxt;

    // One sticky bit per event; a set in the same cycle as a write-one-to-clear wins
    for (genvar i = 0; i < 2; i++) begin : g_status
        assign status_nxt[i] = evt_set[i] || (s_q.status[i] && !(sts_wr && BUS.wdata[i]));
    end

    always_comb begin
        ctl_wr = BUS.wr && hit(BUS.addr, watchdog_interrupt_flag_pkg::WATCHDOG_CONTROL_REG_OFS);
        restart_wr = ctl_wr && BUS.wdata[watchdog_interrupt_flag_pkg::RESTART_BIT_POS];
        // Timeouts only count while the watchdog is enabled
        flag_set = TIMEOUT_EVT && (s_q.reset_en || s_q.int_en)
            || (ctl_wr && BUS.wdata[watchdog_interrupt_flag_pkg::FLAG_POS]);
        flag_rise = flag_set && !s_q.flag;
        expire = s_q.cnt_run && DIV_TICK && (s_q.cnt == watchdog_interrupt_flag_pkg::RST_TICKS_LAST) && !restart_wr;
        sts_wr = BUS.wr && hit(BUS.addr, watchdog_interrupt_flag_pkg::IRQ_STATUS_OFS);
        evt_set[watchdog_interrupt_flag_pkg::EVT_FLAG_POS] = flag_rise;
        evt_set[watchdog_interrupt_flag_pkg::EVT_EXPIRE_POS] = expire;

        s_d = s_q;
        s_d.restart = restart_wr;
        s_d.rdata = '0;

        if (ctl_wr) begin
            s_d.reset_en = BUS.wdata[watchdog_interrupt_flag_pkg::RESET_EN_POS];
            s_d.int_en = BUS.wdata[watchdog_interrupt_flag_pkg::INT_EN_POS];
            if (!BUS.wdata[watchdog_interrupt_flag_pkg::FLAG_POS]) begin
                s_d.flag = 1'b0;
            end
        end
        if (restart_wr) begin
            s_d.psel = BUS.wdata[watchdog_interrupt_flag_pkg::PSEL_HI_POS:watchdog_interrupt_flag_pkg::PSEL_LO_POS];
        end
        // Set after clear so a timeout in the clearing cycle is kept
        if (flag_set) begin
            s_d.flag = 1'b1;
        end

        // Clearing the flag does not touch the counter
        if (restart_wr) begin
            s_d.cnt_run = 1'b0;
            s_d.cnt = '0;
        end else if (flag_rise && !s_q.cnt_run) begin
            s_d.cnt_run = 1'b1;
            s_d.cnt = '0;
        end else if (s_q.cnt_run && DIV_TICK) begin
            if (expire) begin
                s_d.cnt_run = 1'b0;
                s_d.cnt = '0;
            end else begin
                s_d.cnt = s_q.cnt + 10'h001;
            end
        end

        if (expire && s_q.reset_en) begin
            s_d.rst_req = 1'b1;
        end

        s_d.status = status_nxt;
        if (BUS.wr && hit(BUS.addr, watchdog_interrupt_flag_pkg::IRQ_MASK_OFS)) begin
            s_d.mask = BUS.wdata[1:0];
        end

        if (BUS.rd) begin
            case (BUS.addr)
                watchdog_interrupt_flag_pkg::WATCHDOG_CONTROL_REG_OFS: begin
                    s_d.rdata[watchdog_interrupt_flag_pkg::RESET_EN_POS] = s_q.reset_en;
                    s_d.rdata[watchdog_interrupt_flag_pkg::INT_EN_POS] = s_q.int_en;
                    s_d.rdata[watchdog_interrupt_flag_pkg::FLAG_POS] = s_q.flag;
                    s_d.rdata[watchdog_interrupt_flag_pkg::PSEL_HI_POS:watchdog_interrupt_flag_pkg::PSEL_LO_POS] = s_q.psel;
                end
                watchdog_interrupt_flag_pkg::IRQ_STATUS_OFS: s_d.rdata[1:0] = s_q.status;
                watchdog_interrupt_flag_pkg::IRQ_MASK_OFS: s_d.rdata[1:0] = s_q.mask;
                default: s_d.rdata = '0;
            endcase
        end

        // Interrupt stays up while the flag is set and enabled
        s_d.irq = (s_d.flag && s_d.int_en) || (|(s_d.status & s_d.mask));
        s_d.clk_en = s_d.reset_en || s_d.int_en;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            s_q <= '0;
            s_q.psel <= watchdog_interrupt_flag_pkg::PSEL_RST;
            s_q.reset_en <= watchdog_interrupt_flag_pkg::RESET_EN_RST;
            s_q.int_en <= watchdog_interrupt_flag_pkg::INT_EN_RST;
            s_q.mask <= watchdog_interrupt_flag_pkg::MASK_RST;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    assign RD_DATA = s_q.rdata;
    assign WDT_RESTART = s_q.restart;
    assign PERIOD_SEL = s_q.psel;
    assign WDT_CLK_EN = s_q.clk_en;
    assign SYS_RST_REQ = s_q.rst_req;
    assign IRQ = s_q.irq;
endmodule
